// [core/area_sel_pkg.sv]
`default_nettype none
package area_sel_pkg;
    // Register byte addresses on the control bus.
    localparam logic [7:0] OFF_WIDTH = 8'h00;
    localparam logic [7:0] OFF_ASTATE = 8'h04;
    localparam logic [7:0] OFF_WCE = 8'h08;
    localparam logic [7:0] OFF_WSETUP = 8'h0C;
    localparam logic [7:0] OFF_DIR = 8'h10;
    localparam logic [7:0] OFF_SELCTL = 8'h14;
    localparam logic [7:0] OFF_MODE = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    // Field positions.
    localparam int WS_LO_POS = 0;
    localparam int WS_HI_POS = 1;
    localparam int WC_POS = 4;
    localparam int MODE_WIDE_POS = 0;
    localparam int MODE_ROM_POS = 1;
    localparam int MODE_EXP_POS = 2;
    // Reset values.
    localparam logic [7:0] WIDTH_RST = 8'hFF;
    localparam logic [7:0] ASTATE_RST = 8'hFF;
    localparam logic [7:0] WCE_RST = 8'hFF;
    localparam logic [7:0] WSETUP_RST = 8'h33;
    localparam logic [3:0] DIR_ROM_OFF_RST = 4'h1;
    localparam logic [3:0] DIR_ROM_ON_RST = 4'h0;
    localparam logic [3:0] SELCTL_RST = 4'h0;
    // Address map.
    localparam int ADDR_W = 24;
    localparam int NAREA = 8;
    localparam logic [23:0] SMALL_SPAN_MASK = 24'h0FFFFF;
    localparam logic [23:0] ONCHIP_LO_DEF = 24'hFFEF10;
    // Bus response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        WAIT_PROG = 2'b00,
        WAIT_NONE = 2'b01,
        WAIT_PIN1 = 2'b10,
        WAIT_AUTO = 2'b11
    } wait_scheme_t;
    typedef enum logic [2:0] {
        MODE_TWO_STATE = 3'b000,
        MODE_PIN0 = 3'b001,
        MODE_PROG = 3'b010,
        MODE_NOWAIT = 3'b011,
        MODE_PIN1 = 3'b100,
        MODE_AUTO = 3'b101
    } area_mode_t;
endpackage
`default_nettype wire

// [core/area_cfg_if.sv]
`default_nettype none
interface area_cfg_if;
    logic [7:0] area_width_bit;
    logic [7:0] area_three_state_bit;
    logic [7:0] area_wait_ctrl_on_bit;
    logic wait_scheme_hi;
    logic wait_scheme_lo;
    logic [3:0] low_dir;
    logic [3:0] high_enable;
    logic [7:0] area_hit;
    logic external;
    modport regs (output area_width_bit, area_three_state_bit,
        area_wait_ctrl_on_bit, wait_scheme_hi, wait_scheme_lo, low_dir,
        high_enable, input area_hit, external);
    modport decode (input area_width_bit, area_three_state_bit,
        area_wait_ctrl_on_bit, wait_scheme_hi, wait_scheme_lo, low_dir,
        high_enable, output area_hit, external);
endinterface
`default_nettype wire

// [core/area_decoder.sv]
`default_nettype none
module area_decoder (
    // Address of the current access
    input wire logic [23:0] addr,
    input wire logic access_active,
    input wire logic wide_space,
    input wire logic rom_enabled,
    input wire logic [23:0] onchip_lo,
    input wire logic [23:0] rom_hi,
    // Results
    area_cfg_if.decode cfg
);
    logic [2:0] area_idx;
    logic onchip;
    logic onchip_hit;
    logic in_small;
    // Area index is the top three bits of the active span.
    assign in_small = (addr & ~area_sel_pkg::SMALL_SPAN_MASK) == 24'h000000;
    assign area_idx = wide_space ? addr[23:21] : addr[19:17];
    // The 1 MB map folds its on-chip window into the low megabyte.
    assign onchip_hit = wide_space ? addr >= onchip_lo
        : addr[19:0] >= onchip_lo[19:0];
    assign onchip = onchip_hit || (rom_enabled && addr <= rom_hi);
    assign cfg.external = access_active && !onchip
        && (wide_space || in_small);
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_hit
            assign cfg.area_hit[g] = cfg.external
                && (area_idx == 3'(g));
        end
    endgenerate
endmodule
`default_nettype wire

// [core/external_area_select_decode.sv]
// Chosen here: the AXI4-Lite register port and the register addresses.
`default_nettype none
module external_area_select_decode (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Mode straps
    input wire logic wide_space,
    input wire logic rom_enabled,
    input wire logic expanded,
    // Internal bus access
    input wire logic [23:0] bus_addr,
    input wire logic bus_active,
    input wire logic bus_word,
    input wire logic [23:0] rom_hi,
    // External wait pin, active low
    input wire logic ext_wait_n,
    // Select pins
    output logic [7:0] area_select_n_o,
    output logic [7:0] area_select_n_oe,
    // Access attributes of the current external access
    output logic [1:0] lane_en,
    output logic [1:0] access_states,
    output logic [2:0] wait_mode,
    output logic wait_pin0_hold,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    // Register values and decode results meet in one bundle.
    area_cfg_if cfg ();

    // ========================================================
    // Register storage
    logic [7:0] width_q;
    logic [7:0] astate_q;
    logic [7:0] wce_q;
    logic [7:0] wsetup_q;
    logic [3:0] dir_q;
    logic [3:0] selctl_q;
    logic dir_init_q;
    logic [7:0] aw_q;
    logic aw_have_q;
    logic w_have_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic do_write;
    logic aw_hit;
    logic wr_ok;
    // One strobe per register, so the storage processes stay short.
    logic wr_width;
    logic wr_astate;
    logic wr_wce;
    logic wr_wsetup;
    logic wr_dir;
    logic wr_selctl;

    assign cfg.area_width_bit = width_q;
    assign cfg.area_three_state_bit = astate_q;
    assign cfg.area_wait_ctrl_on_bit = wce_q;
    assign cfg.wait_scheme_hi = wsetup_q[area_sel_pkg::WS_HI_POS];
    assign cfg.wait_scheme_lo = wsetup_q[area_sel_pkg::WS_LO_POS];
    assign cfg.low_dir = dir_q;
    assign cfg.high_enable = selctl_q;

    area_decoder u_dec (
        .addr(bus_addr),
        .access_active(bus_active),
        .wide_space(wide_space),
        .rom_enabled(rom_enabled),
        .onchip_lo(area_sel_pkg::ONCHIP_LO_DEF),
        .rom_hi(rom_hi),
        .cfg(cfg)
    );

    // ========================================================
    // Write channel: address and data accepted in either order.
    // A new write is refused until the response has been taken, which
    // keeps a single write in flight at any time.
    assign s_awready = !aw_have_q && !s_bvalid;
    assign s_wready = !w_have_q && !s_bvalid;
    assign do_write = aw_have_q && w_have_q && !s_bvalid;
    assign aw_hit = aw_q == area_sel_pkg::OFF_WIDTH
        || aw_q == area_sel_pkg::OFF_ASTATE
        || aw_q == area_sel_pkg::OFF_WCE
        || aw_q == area_sel_pkg::OFF_WSETUP
        || aw_q == area_sel_pkg::OFF_DIR
        || aw_q == area_sel_pkg::OFF_SELCTL;
    // Only byte lane 0 carries register bits, so its strobe gates the write.
    assign wr_ok = do_write && aw_hit && ws_q[0];
    assign wr_width = wr_ok && aw_q == area_sel_pkg::OFF_WIDTH;
    assign wr_astate = wr_ok && aw_q == area_sel_pkg::OFF_ASTATE;
    assign wr_wce = wr_ok && aw_q == area_sel_pkg::OFF_WCE;
    assign wr_wsetup = wr_ok && aw_q == area_sel_pkg::OFF_WSETUP;
    assign wr_dir = wr_ok && aw_q == area_sel_pkg::OFF_DIR;
    assign wr_selctl = wr_ok && aw_q == area_sel_pkg::OFF_SELCTL;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= area_sel_pkg::RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                aw_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                wd_q <= s_wdata;
                ws_q <= s_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= aw_hit ? area_sel_pkg::RESP_OKAY
                    : area_sel_pkg::RESP_SLVERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Reset leaves every area narrow and slow until software sizes it.
            width_q <= area_sel_pkg::WIDTH_RST;
            astate_q <= area_sel_pkg::ASTATE_RST;
            wce_q <= area_sel_pkg::WCE_RST;
            wsetup_q <= area_sel_pkg::WSETUP_RST;
            selctl_q <= area_sel_pkg::SELCTL_RST;
        end else begin
            if (wr_width) width_q <= wd_q[7:0];
            if (wr_astate) astate_q <= wd_q[7:0];
            if (wr_wce) wce_q <= wd_q[7:0];
            if (wr_wsetup) wsetup_q <= wd_q[7:0];
            if (wr_selctl) selctl_q <= wd_q[3:0];
        end
    end

    // Direction bits take their strap-dependent value on the first edge
    // after reset release, since a strap must not feed an async reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= area_sel_pkg::DIR_ROM_ON_RST;
            dir_init_q <= 1'b0;
        end else if (!dir_init_q) begin
            dir_init_q <= 1'b1;
            dir_q <= (expanded && !rom_enabled)
                ? area_sel_pkg::DIR_ROM_OFF_RST
                : area_sel_pkg::DIR_ROM_ON_RST;
        end else if (wr_dir) begin
            dir_q <= wd_q[3:0];
        end
    end

    // ========================================================
    // Read channel, one cycle after the address is taken.
    // An unmapped offset returns zero data with an error response.
    // Status mirrors the live selects, so it means something only while
    // an access is held on the bus.
    logic [31:0] rd_d;
    logic rd_hit;
    assign s_arready = !s_rvalid;
    assign rd_hit = s_araddr <= area_sel_pkg::OFF_STATUS
        && s_araddr[1:0] == 2'b00;
    always_comb begin
        rd_d = 32'h00000000;
        if (s_araddr == area_sel_pkg::OFF_WIDTH) rd_d[7:0] = width_q;
        else if (s_araddr == area_sel_pkg::OFF_ASTATE) rd_d[7:0] = astate_q;
        else if (s_araddr == area_sel_pkg::OFF_WCE) rd_d[7:0] = wce_q;
        else if (s_araddr == area_sel_pkg::OFF_WSETUP) rd_d[7:0] = wsetup_q;
        else if (s_araddr == area_sel_pkg::OFF_DIR) rd_d[3:0] = dir_q;
        else if (s_araddr == area_sel_pkg::OFF_SELCTL) rd_d[3:0] = selctl_q;
        else if (s_araddr == area_sel_pkg::OFF_MODE) begin
            rd_d[area_sel_pkg::MODE_WIDE_POS] = wide_space;
            rd_d[area_sel_pkg::MODE_ROM_POS] = rom_enabled;
            rd_d[area_sel_pkg::MODE_EXP_POS] = expanded;
        end else if (s_araddr == area_sel_pkg::OFF_STATUS) begin
            rd_d[7:0] = ~area_select_n_o;
            rd_d[10:8] = wait_mode;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= area_sel_pkg::RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_d;
            s_rresp <= rd_hit ? area_sel_pkg::RESP_OKAY
                : area_sel_pkg::RESP_SLVERR;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // ========================================================
    // Select pins are combinational from the address so external SRAM
    // sees them in the same cycle as the address.
    assign area_select_n_o = ~cfg.area_hit;
    // Drive enables come from registers, never from the decode, so a pin
    // that neither software nor the strap-dependent reset value has enabled cannot glitch onto the board.
    assign area_select_n_oe[3:0] = cfg.low_dir;
    assign area_select_n_oe[7:4] = cfg.high_enable;

    // ========================================================
    // Attributes of the current external access.
    logic [2:0] idx;
    logic hit_any;
    logic area_narrow;
    logic area_three;
    logic area_wctl;
    logic [1:0] scheme;
    always_comb begin
        idx = 3'd0;
        for (int i = 0; i < 8; i++) begin
            if (cfg.area_hit[i]) idx = 3'(i);
        end
    end
    assign hit_any = cfg.external;
    assign area_narrow = cfg.area_width_bit[idx];
    assign area_three = cfg.area_three_state_bit[idx];
    assign area_wctl = cfg.area_wait_ctrl_on_bit[idx];
    assign scheme = {cfg.wait_scheme_hi, cfg.wait_scheme_lo};
    // A byte access in a 16-bit area picks its lane from address bit 0:
    // even bytes travel on the upper lane, odd bytes on the lower one.
    assign lane_en = !hit_any ? 2'b11
        : area_narrow ? 2'b10
        : (bus_word ? 2'b11 : {!bus_addr[0], bus_addr[0]});
    assign access_states = (hit_any && area_three) ? 2'd3 : 2'd2;
    // The shared scheme field only matters where the wait controller is on.
    assign wait_mode = !hit_any || !area_three
        ? area_sel_pkg::MODE_TWO_STATE
        : !area_wctl ? area_sel_pkg::MODE_PIN0
        : scheme == area_sel_pkg::WAIT_PROG ? area_sel_pkg::MODE_PROG
        : scheme == area_sel_pkg::WAIT_NONE ? area_sel_pkg::MODE_NOWAIT
        : scheme == area_sel_pkg::WAIT_PIN1 ? area_sel_pkg::MODE_PIN1
        : area_sel_pkg::MODE_AUTO;

    // ========================================================
    // Wait pin: three-stage synchroniser, change accepted once stages
    // two and three agree, then sampled on the falling edge.
    // The settled level costs four cycles of latency, the price of never
    // letting a metastable value reach the falling-edge sampler.
    logic [2:0] wsync_q;
    logic wait_level_q;
    logic wait_fall_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wsync_q <= 3'b111;
            wait_level_q <= 1'b1;
        end else begin
            wsync_q <= {wsync_q[1:0], ext_wait_n};
            if (wsync_q[1] == wsync_q[2]) wait_level_q <= wsync_q[2];
        end
    end
    always_ff @(negedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_fall_q <= 1'b1;
        end else begin
            wait_fall_q <= wait_level_q;
        end
    end
    assign wait_pin0_hold = (wait_mode == area_sel_pkg::MODE_PIN0)
        && !wait_fall_q;
endmodule
`default_nettype wire

// [tb/area_sel_checker.sv]
`default_nettype none
module area_sel_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Straps and access
    input wire logic wide_space,
    input wire logic rom_enabled,
    input wire logic expanded,
    input wire logic [23:0] bus_addr,
    input wire logic bus_active,
    input wire logic bus_word,
    input wire logic [23:0] rom_hi,
    // Results
    input wire logic [7:0] area_select_n_o,
    input wire logic [7:0] area_select_n_oe,
    input wire logic [1:0] lane_en,
    input wire logic [1:0] access_states,
    input wire logic [2:0] wait_mode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Select pins
    sel_onehot_a: assert property ($onehot0(~area_select_n_o))
        else $error("more than one area select low");
    sel_idle_a: assert property (!bus_active |-> &area_select_n_o)
        else $error("select low with no access");
    onchip_high_a: assert property (bus_active && wide_space
        && bus_addr >= 24'hFFEF10 |-> area_select_n_o[0] && area_select_n_o[7])
        else $error("select low on on-chip access");
    rom_high_a: assert property (bus_active && rom_enabled
        && bus_addr <= rom_hi |-> &area_select_n_o)
        else $error("select low on ROM access");
    area_pick_a: assert property (bus_active && wide_space
        && bus_addr < 24'hFFEF10 && !(rom_enabled && bus_addr <= rom_hi)
        |-> area_select_n_o == ~(8'h01 << bus_addr[23:21]))
        else $error("wrong area selected");
    onchip_small_a: assert property (bus_active && !wide_space
        && bus_addr[19:0] >= 20'hFEF10
        |-> area_select_n_o[0] && area_select_n_o[7])
        else $error("select low on on-chip access in small map");
    // ==========================================================
    // Access attributes
    states_mode_a: assert property (!(&area_select_n_o)
        |-> (access_states == 2'h2) == (wait_mode == 3'h0))
        else $error("state count and mode disagree");
    lane_byte_a: assert property (!(&area_select_n_o) && !bus_word
        |-> $onehot(lane_en))
        else $error("byte access on two lanes");
    lane_word_a: assert property (!(&area_select_n_o) && bus_word
        |-> lane_en[1])
        else $error("word access without upper lane");
    plain_access_a: assert property (bus_active && &area_select_n_o
        |-> lane_en == 2'h3 && access_states == 2'h2 && wait_mode == 3'h0)
        else $error("area settings applied to on-chip access");
    oe_reset_a: assert property (!$past(rst_n, 2) && $past(rst_n)
        |-> area_select_n_oe == {7'h0, expanded && !rom_enabled})
        else $error("pin drive wrong after reset");
endmodule
bind external_area_select_decode area_sel_checker u_area_sel_checker (
    .clock, .rst_n, .wide_space, .rom_enabled, .expanded, .bus_addr,
    .bus_active, .bus_word, .rom_hi, .area_select_n_o, .area_select_n_oe,
    .lane_en, .access_states, .wait_mode);
`default_nettype wire

// [tb/ext_device_model.sv]
`default_nettype none
module ext_device_model (
    // Clock
    input wire logic clock,
    // Stall request
    input wire logic go,
    input wire logic [7:0] cycles,
    // Wait pin
    output logic ext_wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q = 8'h0;
    // The pin moves on the falling edge so it never races the sampler.
    always @(negedge clock) begin
        if (go) left_q <= cycles;
        else if (left_q != 8'h0) left_q <= left_q - 8'h1;
    end
    assign ext_wait_n = (left_q == 8'h0);
endmodule
`default_nettype wire

// [tb/external_area_select_decode_test.sv]
`default_nettype none
module external_area_select_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, wide_space = 1, rom_enabled = 0;
    logic expanded = 1, bus_active = 0, bus_word = 0, go = 0;
    logic [23:0] bus_addr = 24'h0, rom_hi = 24'h00FFFF;
    logic [7:0] sel_n, sel_oe, s_awaddr = 8'h0, s_araddr = 8'h0;
    logic [7:0] m_w, m_a, m_c, wcyc = 8'h8;
    logic [1:0] lane_en, states, s_bresp, s_rresp, rsp, m_s;
    logic [2:0] mode;
    logic hold, ext_wait_n, s_awready, s_wready, s_bvalid, s_arready;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
    logic s_rvalid, s_rready = 0;
    logic [3:0] s_wstrb = 4'h0;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd, lfsr = 32'hD763F47E;
    int error_cnt = 0, n_compared = 0;
    always #2 clock = ~clock;
    external_area_select_decode u_external_area_select_decode (
        .clock, .rst_n, .wide_space, .rom_enabled, .expanded, .bus_addr,
        .bus_active, .bus_word, .rom_hi, .ext_wait_n,
        .area_select_n_o(sel_n), .area_select_n_oe(sel_oe), .lane_en,
        .access_states(states), .wait_mode(mode), .wait_pin0_hold(hold),
        .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    ext_device_model u_ext_device_model (.clock, .go, .cycles(wcyc),
        .ext_wait_n);
    // ==========================================================
    // Helpers
    task automatic check(string what, logic [31:0] seen, logic [31:0] ex);
        n_compared++;
        if (seen !== ex) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, ex, seen);
        end
    endtask
    function automatic logic [31:0] next_rand(logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    task automatic axi_wr(logic [7:0] a, logic [31:0] d);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hF;
        s_awvalid <= 1;
        s_wvalid <= 1;
        s_bready <= 1;
        do begin
            @(posedge clock);
            if (s_awready) s_awvalid <= 0;
            if (s_wready) s_wvalid <= 0;
        end while (s_bvalid !== 1'b1);
        rsp = s_bresp;
        s_bready <= 0;
        @(posedge clock);
    endtask
    task automatic axi_rd(logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1;
        s_rready <= 1;
        do begin
            @(posedge clock);
            if (s_arready) s_arvalid <= 0;
        end while (s_rvalid !== 1'b1);
        rd = s_rdata;
        rsp = s_rresp;
        s_rready <= 0;
        @(posedge clock);
    endtask
    task automatic cfg(logic [7:0] w, logic [7:0] a, logic [7:0] c,
        logic [1:0] s);
        axi_wr(area_sel_pkg::OFF_WIDTH, {24'h0, w});
        axi_wr(area_sel_pkg::OFF_ASTATE, {24'h0, a});
        axi_wr(area_sel_pkg::OFF_WCE, {24'h0, c});
        axi_wr(area_sel_pkg::OFF_WSETUP, {30'h0, s});
        {m_w, m_a, m_c, m_s} = {w, a, c, s};
    endtask
    function automatic logic [2:0] exp_mode(int k);
        if (!m_a[k]) return area_sel_pkg::MODE_TWO_STATE;
        if (!m_c[k]) return area_sel_pkg::MODE_PIN0;
        return 3'h2 + m_s;
    endfunction
    task automatic access(logic [23:0] a, logic w);
        int k;
        logic ext;
        logic [7:0] es;
        logic [1:0] el;
        bus_addr <= a;
        bus_word <= w;
        bus_active <= 1;
        @(negedge clock);
        ext = (wide_space ? a < 24'hFFEF10
            : a[23:20] == 4'h0 && a[19:0] < 20'hFEF10)
            && !(rom_enabled && a <= rom_hi);
        k = wide_space ? a[23:21] : a[19:17];
        es = ext ? ~(8'h01 << k) : 8'hFF;
        el = m_w[k] ? 2'h2 : w ? 2'h3 : {!a[0], a[0]};
        check("select", sel_n, es);
        if (ext) begin
            check("lanes", lane_en, el);
            check("states", states, m_a[k] ? 2'h3 : 2'h2);
            check("mode", mode, exp_mode(k));
        end else begin
            check("lanes idle", lane_en, 2'h3);
            check("states idle", states, 2'h2);
            check("mode idle", mode, area_sel_pkg::MODE_TWO_STATE);
        end
        @(posedge clock);
    endtask
    // ==========================================================
    // Scenarios
    task automatic do_reset;
        logic [31:0] rv [7];
        rst_n <= 0;
        bus_active <= 0;
        repeat (5) @(posedge clock);
        rst_n <= 1;
        repeat (2) @(posedge clock);
        rv = '{32'hFF, 32'hFF, 32'hFF, 32'h33, expanded && !rom_enabled,
            32'h0, {expanded, rom_enabled, wide_space}};
        check("oe", sel_oe, rv[4]);
        for (int i = 0; i < 7; i++) begin
            axi_rd(8'(4 * i));
            check("reset value", rd, rv[i]);
        end
        {m_w, m_a, m_c, m_s} = {24'hFFFFFF, 2'h3};
    endtask
    task automatic sweep;
        logic [23:0] a;
        for (int i = 0; i < 48; i++) begin
            lfsr = next_rand(lfsr);
            if (i % 8 == 0)
                cfg(lfsr[7:0], lfsr[15:8], lfsr[23:16], lfsr[25:24]);
            a = wide_space ? lfsr[23:0] : {4'h0, lfsr[19:0]};
            if (lfsr[31:29] == 3'h7) begin
                a = 24'hFFEF10 | lfsr[7:0];
                if (!wide_space) a[23:20] = 4'h0;
            end
            if (!wide_space && lfsr[28:26] == 3'h1) a[20] = 1'b1;
            if (lfsr[28:26] == 3'h0) a = {8'h0, lfsr[15:0]};
            access(a & {23'h7FFFFF, !lfsr[30]}, lfsr[30]);
        end
    endtask
    initial begin
        do_reset();
        axi_rd(8'h20);
        check("rresp", rsp, area_sel_pkg::RESP_SLVERR);
        axi_wr(8'h24, 32'h0);
        check("bresp", rsp, area_sel_pkg::RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            axi_wr(area_sel_pkg::OFF_DIR, {28'h0, lfsr[3:0]});
            axi_wr(area_sel_pkg::OFF_SELCTL, {28'h0, lfsr[7:4]});
            check("oe", sel_oe, lfsr[7:0]);
        end
        sweep();
        wide_space <= 0;
        sweep();
        cfg(8'h00, 8'hFF, 8'h00, 2'h0);
        wide_space <= 1;
        access(24'h400000, 1'b1);
        go <= 1;
        @(posedge clock);
        go <= 0;
        repeat (5) @(posedge clock);
        check("wait hold", hold, 1'b1);
        axi_rd(area_sel_pkg::OFF_STATUS);
        check("status", rd[10:0], {area_sel_pkg::MODE_PIN0, 8'h04});
        repeat (8) @(posedge clock);
        check("wait hold", hold, 1'b0);
        rom_enabled <= 1;
        do_reset();
        sweep();
        final_report();
    end
    // A full run needs under 600 cycles; the limit leaves wide margin.
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
